// ===== logic/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

  // Command codes
  localparam logic [7:0] OP_SET_CURSOR = 8'h21;
  localparam logic [7:0] OP_SET_OFFSET = 8'h22;
  localparam logic [7:0] OP_SET_POINTER = 8'h24;
  localparam logic [4:0] OP_CURSOR_PATTERN_HI = 5'h14;
  localparam logic [7:0] OP_AUTO_WRITE = 8'hB0;
  localparam logic [7:0] OP_AUTO_READ = 8'hB1;
  localparam logic [7:0] OP_AUTO_RESET = 8'hB2;
  localparam logic [7:0] OP_WRITE_INC = 8'hC0;
  localparam logic [7:0] OP_READ_INC = 8'hC1;
  localparam logic [7:0] OP_WRITE_DEC = 8'hC2;
  localparam logic [7:0] OP_READ_DEC = 8'hC3;
  localparam logic [7:0] OP_WRITE_HOLD = 8'hC4;
  localparam logic [7:0] OP_READ_HOLD = 8'hC5;
  localparam logic [7:0] OP_SCREEN_PEEK = 8'hE0;
  localparam logic [7:0] OP_SCREEN_COPY = 8'hE8;
  localparam logic [3:0] OP_BIT_OP_HI = 4'hF;

  // Field positions
  localparam int BIT_SEL_POS = 0;
  localparam int BIT_SEL_W = 3;
  localparam int BIT_VALUE_POS = 3;
  localparam int STEP_DEC_POS = 1;
  localparam int STEP_HOLD_POS = 2;
  localparam int COLUMN_W = 7;
  localparam int ROW_W = 5;
  localparam int OFFSET_W = 5;
  localparam int HEIGHT_W = 4;
  localparam int GLYPH_ROW_W = 3;

  // Status bit positions
  localparam int STATUS_CMD_READY = 0;
  localparam int STATUS_DATA_READY = 1;
  localparam int STATUS_AUTO_READ_READY = 2;
  localparam int STATUS_AUTO_WRITE_READY = 3;
  localparam int STATUS_CTRL_READY = 5;
  localparam int STATUS_PEEK_COPY_ERROR = 6;

  // Reset values and step constants
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [6:0] COLUMN_RESET = 7'h00;
  localparam logic [4:0] ROW_RESET = 5'h00;
  localparam logic [4:0] OFFSET_RESET = 5'h00;
  localparam logic [3:0] HEIGHT_RESET = 4'h8;
  localparam logic [15:0] POINTER_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] HEIGHT_ONE = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_BIT = 2'b10,
    ST_COPY = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    AUTO_OFF = 2'b00,
    AUTO_WRITE = 2'b01,
    AUTO_READ = 2'b10
  } auto_mode_t;

  typedef enum logic [1:0] {
    STEP_HOLD = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10
  } ptr_step_t;

endpackage

// ===== logic/glyph_address_former.sv
module glyph_address_former (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic glyph_req,
  input wire logic [4:0] cg_offset,
  input wire logic [7:0] glyph_code,
  input wire logic [2:0] glyph_row,
  input wire logic cg_external_mode,
  output logic [15:0] glyph_addr,
  output logic glyph_from_ram,
  output logic glyph_valid
);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      glyph_addr <= 16'h0000;
      glyph_from_ram <= 1'b0;
      glyph_valid <= 1'b0;
    end else begin
      glyph_valid <= glyph_req;
      if (glyph_req) begin
        glyph_addr <= {cg_offset, glyph_code, glyph_row};
        glyph_from_ram <= cg_external_mode | glyph_code[7];
      end
    end
  end

endmodule

// ===== logic/lcd_controller_command_decoder.sv
// What this block does
// - B0 enters auto write, B1 auto read, B2 leaves either auto mode.
// - C0 writes last operand at pointer then increments; C1 reads and increments.
// - C2 writes operand then decrements pointer; C3 reads and decrements.
// - C4 writes and C5 reads one byte, pointer left unchanged.
// - F0-F7 clear, F8-FF set the bit chosen by low three code bits.
// - Only command 21H moves the cursor: column operand first, row second.
// - Memory reads and writes never touch the cursor position.
// - Cursor column keeps low 7 bits, row keeps low 5 bits.
// - Command 22H loads offset from first operand; host sends 00H second.
// - Glyph address is offset, then character code, then row bits.
// - The three low glyph address bits pick one of eight glyph rows.
// - Internal mode: codes 00H-7FH from ROM, 80H-FFH from external RAM.
// - External mode: all 256 codes come from external RAM.
// - In auto modes readiness shows on status bits 2 and 3.
// - Status bit 6 flags a failed screen peek or screen copy.
module lcd_controller_command_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_cd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic [7:0] status_byte,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic screen_area_ok,
  input wire logic [15:0] copy_target_addr,
  output logic [15:0] memory_address_pointer,
  output logic [6:0] cursor_column,
  output logic [4:0] cursor_row,
  output logic [3:0] cursor_height,
  output logic [4:0] cg_offset,
  input wire logic cg_external_mode,
  input wire logic glyph_req,
  input wire logic [7:0] glyph_code,
  input wire logic [2:0] glyph_row,
  output logic [15:0] glyph_addr,
  output logic glyph_from_ram,
  output logic glyph_valid
);

  lcd_cmd_pkg::seq_state_t state_r;
  lcd_cmd_pkg::auto_mode_t auto_r;
  lcd_cmd_pkg::ptr_step_t step_r;
  logic [7:0] cmd_r;
  logic [7:0] op_first_r;
  logic [7:0] op_last_r;
  logic [15:0] ptr_r;
  logic error_r;

  logic idle;
  logic in_auto;
  logic cmd_take;
  logic data_take;
  logic cmd_acc;
  logic is_wr1;
  logic is_rd1;
  logic is_bit;
  logic is_peek;
  logic is_copy;
  logic peek_go;
  logic copy_go;
  logic auto_wr_data;
  logic auto_rd;
  logic [7:0] bit_mask;
  logic [7:0] bit_result;
  lcd_cmd_pkg::ptr_step_t op_step;

  function automatic lcd_cmd_pkg::ptr_step_t step_of(input logic [7:0] code);
    if (code[lcd_cmd_pkg::STEP_HOLD_POS]) begin
      step_of = lcd_cmd_pkg::STEP_HOLD;
    end else if (code[lcd_cmd_pkg::STEP_DEC_POS]) begin
      step_of = lcd_cmd_pkg::STEP_DEC;
    end else begin
      step_of = lcd_cmd_pkg::STEP_INC;
    end
  endfunction

  function automatic logic [15:0] apply_step(input logic [15:0] p, input lcd_cmd_pkg::ptr_step_t s);
    case (s)
      lcd_cmd_pkg::STEP_INC: apply_step = p + lcd_cmd_pkg::POINTER_ONE;
      lcd_cmd_pkg::STEP_DEC: apply_step = p - lcd_cmd_pkg::POINTER_ONE;
      default: apply_step = p;
    endcase
  endfunction

  // Command and data decode
  assign idle = (state_r == lcd_cmd_pkg::ST_IDLE);
  assign in_auto = (auto_r != lcd_cmd_pkg::AUTO_OFF);
  assign cmd_take = host_wr & host_cd & idle;
  assign data_take = host_wr & ~host_cd & idle;
  assign cmd_acc = cmd_take & (~in_auto | (host_wdata == lcd_cmd_pkg::OP_AUTO_RESET));
  assign is_wr1 = cmd_acc & ((host_wdata == lcd_cmd_pkg::OP_WRITE_INC) |
                  (host_wdata == lcd_cmd_pkg::OP_WRITE_DEC) |
                  (host_wdata == lcd_cmd_pkg::OP_WRITE_HOLD));
  assign is_rd1 = cmd_acc & ((host_wdata == lcd_cmd_pkg::OP_READ_INC) |
                  (host_wdata == lcd_cmd_pkg::OP_READ_DEC) |
                  (host_wdata == lcd_cmd_pkg::OP_READ_HOLD));
  assign is_bit = cmd_acc & (host_wdata[7:4] == lcd_cmd_pkg::OP_BIT_OP_HI);
  assign is_peek = cmd_acc & (host_wdata == lcd_cmd_pkg::OP_SCREEN_PEEK);
  assign is_copy = cmd_acc & (host_wdata == lcd_cmd_pkg::OP_SCREEN_COPY);
  assign peek_go = is_peek & screen_area_ok;
  assign copy_go = is_copy & screen_area_ok;
  assign auto_wr_data = data_take & (auto_r == lcd_cmd_pkg::AUTO_WRITE);
  assign auto_rd = host_rd & ~host_cd & idle & (auto_r == lcd_cmd_pkg::AUTO_READ);
  assign op_step = step_of(host_wdata);

  // Read-modify-write of the selected bit
  assign bit_mask = lcd_cmd_pkg::BYTE_ONE << cmd_r[lcd_cmd_pkg::BIT_SEL_POS +: lcd_cmd_pkg::BIT_SEL_W];
  assign bit_result = cmd_r[lcd_cmd_pkg::BIT_VALUE_POS] ? (mem_rdata | bit_mask)
                                                        : (mem_rdata & ~bit_mask);

  // Status byte
  always_comb begin
    status_byte = 8'h00;
    status_byte[lcd_cmd_pkg::STATUS_CMD_READY] = idle & ~in_auto;
    status_byte[lcd_cmd_pkg::STATUS_DATA_READY] = idle & ~in_auto;
    status_byte[lcd_cmd_pkg::STATUS_AUTO_READ_READY] = idle & (auto_r == lcd_cmd_pkg::AUTO_READ);
    status_byte[lcd_cmd_pkg::STATUS_AUTO_WRITE_READY] = idle & (auto_r == lcd_cmd_pkg::AUTO_WRITE);
    status_byte[lcd_cmd_pkg::STATUS_CTRL_READY] = idle;
    status_byte[lcd_cmd_pkg::STATUS_PEEK_COPY_ERROR] = error_r;
  end

  // Operand capture, newest two kept
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_first_r <= 8'h00;
      op_last_r <= 8'h00;
    end else if (data_take & ~in_auto) begin
      op_first_r <= op_last_r;
      op_last_r <= host_wdata;
    end
  end

  // Auto mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      auto_r <= lcd_cmd_pkg::AUTO_OFF;
    end else if (cmd_acc) begin
      if (host_wdata == lcd_cmd_pkg::OP_AUTO_WRITE) begin
        auto_r <= lcd_cmd_pkg::AUTO_WRITE;
      end else if (host_wdata == lcd_cmd_pkg::OP_AUTO_READ) begin
        auto_r <= lcd_cmd_pkg::AUTO_READ;
      end else if (host_wdata == lcd_cmd_pkg::OP_AUTO_RESET) begin
        auto_r <= lcd_cmd_pkg::AUTO_OFF;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= lcd_cmd_pkg::ST_IDLE;
    end else begin
      case (state_r)
        lcd_cmd_pkg::ST_IDLE: begin
          if (is_rd1 | auto_rd | peek_go) begin
            state_r <= lcd_cmd_pkg::ST_READ;
          end else if (is_bit) begin
            state_r <= lcd_cmd_pkg::ST_BIT;
          end else if (copy_go) begin
            state_r <= lcd_cmd_pkg::ST_COPY;
          end
        end
        lcd_cmd_pkg::ST_READ, lcd_cmd_pkg::ST_BIT, lcd_cmd_pkg::ST_COPY: begin
          if (mem_rvalid) begin
            state_r <= lcd_cmd_pkg::ST_IDLE;
          end
        end
        default: state_r <= lcd_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Command and pending pointer step
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_r <= 8'h00;
      step_r <= lcd_cmd_pkg::STEP_HOLD;
    end else if (idle & (cmd_acc | auto_rd)) begin
      cmd_r <= host_wdata;
      if (is_rd1) begin
        step_r <= op_step;
      end else if (auto_rd) begin
        step_r <= lcd_cmd_pkg::STEP_INC;
      end else begin
        step_r <= lcd_cmd_pkg::STEP_HOLD;
      end
    end
  end

  // Address pointer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_r <= lcd_cmd_pkg::POINTER_RESET;
    end else if (cmd_acc & (host_wdata == lcd_cmd_pkg::OP_SET_POINTER)) begin
      ptr_r <= {op_last_r, op_first_r};
    end else if (is_wr1) begin
      ptr_r <= apply_step(ptr_r, op_step);
    end else if (auto_wr_data) begin
      ptr_r <= ptr_r + lcd_cmd_pkg::POINTER_ONE;
    end else if ((state_r == lcd_cmd_pkg::ST_READ) & mem_rvalid) begin
      ptr_r <= apply_step(ptr_r, step_r);
    end
  end

  assign memory_address_pointer = ptr_r;

  // Display memory requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_req <= 1'b0;
      if (auto_wr_data) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= ptr_r;
        mem_wdata <= host_wdata;
      end else if (is_wr1) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= ptr_r;
        mem_wdata <= op_last_r;
      end else if (is_rd1 | auto_rd | is_bit | peek_go | copy_go) begin
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_addr <= ptr_r;
      end else if ((state_r == lcd_cmd_pkg::ST_BIT) & mem_rvalid) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= ptr_r;
        mem_wdata <= bit_result;
      end else if ((state_r == lcd_cmd_pkg::ST_COPY) & mem_rvalid) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= copy_target_addr;
        mem_wdata <= mem_rdata;
      end
    end
  end

  // Read data to host
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= (state_r == lcd_cmd_pkg::ST_READ) & mem_rvalid;
      if ((state_r == lcd_cmd_pkg::ST_READ) & mem_rvalid) begin
        host_rdata <= mem_rdata;
      end
    end
  end

  // Peek and copy error flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      error_r <= 1'b0;
    end else if (is_peek | is_copy) begin
      error_r <= ~screen_area_ok;
    end
  end

  // Cursor position, only from the cursor command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cursor_column <= lcd_cmd_pkg::COLUMN_RESET;
      cursor_row <= lcd_cmd_pkg::ROW_RESET;
    end else if (cmd_acc & (host_wdata == lcd_cmd_pkg::OP_SET_CURSOR)) begin
      cursor_column <= op_first_r[lcd_cmd_pkg::COLUMN_W-1:0];
      cursor_row <= op_last_r[lcd_cmd_pkg::ROW_W-1:0];
    end
  end

  // Cursor height
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cursor_height <= lcd_cmd_pkg::HEIGHT_RESET;
    end else if (cmd_acc & (host_wdata[7:3] == lcd_cmd_pkg::OP_CURSOR_PATTERN_HI)) begin
      cursor_height <= {1'b0, host_wdata[2:0]} + lcd_cmd_pkg::HEIGHT_ONE;
    end
  end

  // Glyph generator offset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cg_offset <= lcd_cmd_pkg::OFFSET_RESET;
    end else if (cmd_acc & (host_wdata == lcd_cmd_pkg::OP_SET_OFFSET)) begin
      cg_offset <= op_first_r[lcd_cmd_pkg::OFFSET_W-1:0];
    end
  end

  glyph_address_former glyph_address_former_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .glyph_req(glyph_req),
    .cg_offset(cg_offset),
    .glyph_code(glyph_code),
    .glyph_row(glyph_row),
    .cg_external_mode(cg_external_mode),
    .glyph_addr(glyph_addr),
    .glyph_from_ram(glyph_from_ram),
    .glyph_valid(glyph_valid)
  );

endmodule

// ===== verif/lcd_mem_model.sv
module lcd_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [7:0] q_r;
  logic [15:0] a_r;
  logic [1:0] cnt_r;
  logic pend_r;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Idle data lines show the inverse of the last byte
  assign mem_rdata = mem_rvalid ? q_r : ~q_r;
  always @(posedge clk_sys) begin
    mem_rvalid <= 1'b0;
    if (rst) begin
      pend_r <= 1'b0;
      q_r <= 8'h00;
    end else if (mem_req && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end else if (mem_req && !slow) begin
      mem_rvalid <= 1'b1;
      q_r <= mem[mem_addr];
    end else if (mem_req) begin
      a_r <= mem_addr;
      cnt_r <= 2'h2;
      pend_r <= 1'b1;
    end else if (pend_r && cnt_r == 2'h0) begin
      mem_rvalid <= 1'b1;
      q_r <= mem[a_r];
      pend_r <= 1'b0;
    end else if (pend_r) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// ===== verif/lcd_controller_command_decoder_asserts.sv
module lcd_controller_command_decoder_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_cd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] status_byte,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic screen_area_ok,
  input wire logic [15:0] memory_address_pointer,
  input wire logic [6:0] cursor_column,
  input wire logic [4:0] cursor_row,
  input wire logic [4:0] cg_offset,
  input wire logic cg_external_mode,
  input wire logic glyph_req,
  input wire logic [7:0] glyph_code,
  input wire logic [2:0] glyph_row,
  input wire logic [15:0] glyph_addr,
  input wire logic glyph_from_ram
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] op_old_r;
  logic [7:0] op_new_r;
  logic cmd_ok;
  logic cur_cmd;
  logic code_hi;
  assign cmd_ok = host_wr && host_cd && status_byte[0];
  assign cur_cmd = cmd_ok && host_wdata == 8'h21;
  assign code_hi = glyph_code[7];
  // Last two operand bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_old_r <= 8'h00;
      op_new_r <= 8'h00;
    end else if (host_wr && !host_cd && status_byte[0]) begin
      op_old_r <= op_new_r;
      op_new_r <= host_wdata;
    end
  end
  a_reset_values: assert property ($fell(rst) |-> status_byte == 8'h23) else $error("bad reset status");
  a_auto_status: assert property (status_byte[2] || status_byte[3] |-> !status_byte[0] && !status_byte[1])
    else $error("auto status bits overlap");
  a_auto_enter: assert property (cmd_ok && host_wdata == 8'hB0 |=> status_byte[3] && !status_byte[2])
    else $error("auto write not entered");
  a_cursor_load: assert property (cur_cmd |=>
    cursor_column == op_old_r[6:0] && cursor_row == op_new_r[4:0]) else $error("cursor load wrong");
  a_cursor_only: assert property ($changed(cursor_column) || $changed(cursor_row) |-> $past(cur_cmd))
    else $error("cursor moved without command");
  a_offset_load: assert property (cmd_ok && host_wdata == 8'h22 |=> cg_offset == op_old_r[4:0])
    else $error("offset load wrong");
  a_write_inc: assert property (cmd_ok && host_wdata == 8'hC0 |=> mem_req && mem_we && mem_wdata == op_new_r
    && mem_addr == $past(memory_address_pointer)) else $error("write request wrong");
  a_glyph_form: assert property (glyph_req |=>
    glyph_addr == {$past(cg_offset), $past(glyph_code), $past(glyph_row)}) else $error("glyph address wrong");
  a_glyph_source: assert property (glyph_req |=>
    glyph_from_ram == ($past(cg_external_mode) || $past(code_hi))) else $error("glyph source wrong");
  a_peek_error: assert property (cmd_ok && host_wdata == 8'hE0 && !screen_area_ok |->
    ##[1:20] status_byte[6]) else $error("peek error not flagged");
  c_auto_write: cover property (cmd_ok && host_wdata == 8'hB0);
  c_bit_op: cover property (cmd_ok && host_wdata[7:4] == 4'hF);
  c_glyph_ext: cover property (glyph_req && cg_external_mode);
endmodule
bind lcd_controller_command_decoder lcd_controller_command_decoder_asserts lcd_controller_command_decoder_asserts_inst (
  .clk_sys, .rst, .host_wr, .host_cd, .host_wdata, .status_byte, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .screen_area_ok, .memory_address_pointer, .cursor_column, .cursor_row, .cg_offset, .cg_external_mode,
  .glyph_req, .glyph_code, .glyph_row, .glyph_addr, .glyph_from_ram);

// ===== verif/lcd_controller_command_decoder_tb_top.sv
module lcd_controller_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] cmd; logic [7:0] dat; logic [15:0] ptr;} row_t;
  row_t rows [6] = '{'{8'hC0, 8'hA5, 16'h0101}, '{8'hC1, 8'hA5, 16'h0101}, '{8'hC2, 8'h3C, 16'h00FF},
    '{8'hC3, 8'h3C, 16'h00FF}, '{8'hC4, 8'h5A, 16'h0100}, '{8'hC5, 8'h5A, 16'h0100}};
  logic clk_sys = 1'b0;
  logic rst, host_wr, host_rd, host_cd, mem_we, mem_req, mem_rvalid, screen_area_ok, slow;
  logic host_rvalid, cg_external_mode, glyph_req, glyph_from_ram, glyph_valid;
  logic [7:0] host_wdata, host_rdata, status_byte, mem_wdata, mem_rdata, glyph_code, v, e;
  logic [15:0] mem_addr, copy_target_addr, memory_address_pointer, glyph_addr;
  logic [6:0] cursor_column;
  logic [4:0] cursor_row, cg_offset;
  logic [3:0] cursor_height;
  logic [2:0] glyph_row;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  lcd_controller_command_decoder lcd_controller_command_decoder_inst (.clk_sys, .rst, .host_wr, .host_rd, .host_cd,
    .host_wdata, .host_rdata, .host_rvalid, .status_byte, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_rvalid, .screen_area_ok, .copy_target_addr, .memory_address_pointer, .cursor_column, .cursor_row,
    .cursor_height, .cg_offset, .cg_external_mode, .glyph_req, .glyph_code, .glyph_row, .glyph_addr,
    .glyph_from_ram, .glyph_valid);
  lcd_mem_model lcd_mem_model_inst (.clk_sys, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_rvalid);
  task end_sim;
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", n, x, g);
      error_cnt++;
    end
  endtask
  task chk16(input string n, input logic [15:0] x, input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", n, x, g);
      error_cnt++;
    end
  endtask
  task poll(input int b);
    int i;
    i = 0;
    while (status_byte[b] !== 1'b1 && i < 100) begin
      @(negedge clk_sys);
      i++;
    end
    if (i == 100) error_cnt++;
  endtask
  task wr(input logic cd, input logic [7:0] d, input int b);
    poll(b);
    host_cd = cd;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk_sys);
    host_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task rd_wait;
    int i;
    i = 0;
    while (host_rvalid !== 1'b1 && i < 100) begin
      @(negedge clk_sys);
      i++;
    end
    v = host_rdata;
    if (i == 100) error_cnt++;
  endtask
  task set_ptr(input logic [15:0] p);
    wr(1'b0, p[7:0], 0);
    wr(1'b0, p[15:8], 0);
    wr(1'b1, 8'h24, 0);
  endtask
  task chk_reset;
    chk8("status", 8'h23, status_byte);
    chk16("pointer", 16'h0000, memory_address_pointer);
    chk8("height", {4'h0, lcd_cmd_pkg::HEIGHT_RESET}, {4'h0, cursor_height});
    chk8("offset", 8'h00, {3'h0, cg_offset});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {rst, host_wr, host_rd, host_cd, screen_area_ok, slow, cg_external_mode, glyph_req} = 8'h80;
    {host_wdata, glyph_code, glyph_row, copy_target_addr} = 35'h0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk_reset();
    wr(1'b0, 8'hCF, 0);
    wr(1'b0, 8'hFF, 0);
    wr(1'b1, 8'h21, 0);
    chk8("row", 8'h1F, {3'h0, cursor_row});
    wr(1'b0, 8'h4F, 0);
    wr(1'b0, 8'h0F, 0);
    wr(1'b1, 8'h21, 0);
    chk8("row", 8'h0F, {3'h0, cursor_row});
    foreach (rows[k]) begin
      set_ptr(16'h0100);
      if (!rows[k].cmd[0]) wr(1'b0, rows[k].dat, 0);
      wr(1'b1, rows[k].cmd, 0);
      if (rows[k].cmd[0]) rd_wait();
      else v = lcd_mem_model_inst.mem[16'h0100];
      chk8("data", rows[k].dat, v);
      poll(0);
      chk16("pointer", rows[k].ptr, memory_address_pointer);
      chk8("column", 8'h4F, {1'b0, cursor_column});
    end
    for (int n = 0; n < 8; n++) begin
      wr(1'b1, 8'hA0 | 8'(n), 0);
      chk8("height", 8'(n + 1), {4'h0, cursor_height});
    end
    slow = 1'b1;
    e = 8'h5A;
    for (int i = 0; i < 8; i++) begin
      for (int s = 1; s >= 0; s--) begin
        wr(1'b1, {4'hF, s[0], i[2:0]}, 0);
        poll(0);
        repeat (2) @(negedge clk_sys);
        e[i] = s[0];
        chk8("bit op", e, lcd_mem_model_inst.mem[16'h0100]);
      end
    end
    wr(1'b1, 8'hB0, 0);
    chk8("auto status", 8'h08, status_byte & 8'h0F);
    wr(1'b0, 8'h11, 3);
    wr(1'b0, 8'h22, 3);
    wr(1'b1, 8'hB2, 5);
    poll(0);
    chk16("pointer", 16'h0102, memory_address_pointer);
    set_ptr(16'h0100);
    wr(1'b1, 8'hB1, 0);
    chk8("auto status", 8'h04, status_byte & 8'h0F);
    for (int j = 1; j < 3; j++) begin
      poll(2);
      host_cd = 1'b0;
      host_rd = 1'b1;
      @(negedge clk_sys);
      host_rd = 1'b0;
      rd_wait();
      chk8("auto read", 8'(8'h11 * j), v);
    end
    wr(1'b1, 8'hB2, 5);
    wr(1'b0, 8'h02, 0);
    wr(1'b0, 8'h00, 0);
    wr(1'b1, 8'h22, 0);
    chk8("offset", 8'h02, {3'h0, cg_offset});
    for (int j = 0; j < 3; j++) begin
      glyph_code = (j == 0) ? 8'h80 : 8'h7F;
      glyph_row = 3'(j * 3);
      cg_external_mode = (j == 2);
      glyph_req = 1'b1;
      @(negedge clk_sys);
      glyph_req = 1'b0;
      chk16("glyph addr", {5'h02, glyph_code, glyph_row}, glyph_addr);
      chk8("glyph src", {7'h0, j != 1}, {7'h0, glyph_from_ram});
      chk8("glyph valid", 8'h01, {7'h0, glyph_valid});
    end
    set_ptr(16'h0101);
    wr(1'b1, 8'hE0, 0);
    poll(0);
    chk8("error flag", 8'h40, status_byte & 8'h40);
    screen_area_ok = 1'b1;
    wr(1'b1, 8'hE0, 0);
    rd_wait();
    chk8("peek", 8'h22, v);
    poll(0);
    chk8("error flag", 8'h00, status_byte & 8'h40);
    copy_target_addr = 16'h0200;
    wr(1'b1, 8'hE8, 0);
    poll(0);
    repeat (2) @(negedge clk_sys);
    chk8("copy", 8'h22, lcd_mem_model_inst.mem[16'h0200]);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk_reset();
    end_sim();
  end
endmodule
